// >>> verilog/sag_guard.sv
// Mode-based access guard between the core register port and the register bank
//
// Function
// - Reset loads restrictive defaults into every memory management attribute.
// - Software may change memory management attributes within the mode restrictions.
// - Writes to the descriptor list pointer are taken only in system mode.
// - Memory management configuration registers are readable and writable only in system mode.
// - System mode reaches all hardware-unit registers.
// - Without configuration, user mode reaches only the core's own registers.
// - User mode reaches a hardware unit only when its grant bit is set.
// - Reset gives every register a defined value and defined permissions.
// - Permissions are fixed except the user and contactless firmware unit grants.
// - User, system and highest-privilege levels are told apart, each with its stack limit.
`timescale 1ns/100ps
module sag_guard
	import sag_pkg::*;
#(
	parameter int UNIT_N = SAG_UNIT_N
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	input wire sag_req_t core_req,
	output logic [SAG_DATA_W-1:0] core_rdata,
	output logic core_denied,
	output sag_bank_req_t bank_req,
	input wire logic [SAG_DATA_W-1:0] bank_rdata,
	input wire logic [1:0] stack_lim_wr,
	input wire logic [7:0] stack_lim_wdata,
	output sag_level_t priv_level,
	output logic [7:0] stack_limit,
	output logic [15:0] desc_list_ptr,
	output logic viol_flag
);

	////////////////////////////////////////////////////////////////////////////
	// Address classification and privilege level

	logic is_core;
	logic is_mmu;
	logic is_unit;
	logic [2:0] unit_sel;
	logic [UNIT_N-1:0] user_grant_r;
	logic [UNIT_N-1:0] cfw_grant_r;
	logic [15:0] desc_ptr_r;
	logic viol_r;
	logic viol_wr_r;
	logic [7:0] stack_lim_r [3];
	logic allow;
	logic access;
	logic grant_bit;
	logic mmu_wr;
	logic viol_clr;
	logic [SAG_DATA_W-1:0] viol_stat;

	assign is_core = core_req.addr >= SAG_CORE_BASE && core_req.addr <= SAG_CORE_LAST;
	assign is_mmu = core_req.addr >= SAG_MMU_BASE && core_req.addr <= SAG_MMU_LAST;
	assign is_unit = core_req.addr >= SAG_UNIT_BASE && core_req.addr <= SAG_UNIT_LAST;
	assign unit_sel = core_req.addr[SAG_UNIT_SEL_LSB +: 3];
	assign access = core_req.rd | core_req.wr;
	assign mmu_wr = clk_en & core_req.wr & allow & is_mmu;
	// Only an allowed write may clear, so user code cannot hide its own refusal
	assign viol_clr = core_req.wr & allow & (core_req.addr == SAG_VIOL_STAT)
		& core_req.wdata[SAG_VIOL_FLAG_BIT];

	always_comb begin
		case (core_req.mode)
			SAG_MODE_USER: priv_level = SAG_LVL_USER;
			SAG_MODE_SYSTEM: priv_level = SAG_LVL_SYSTEM;
			SAG_MODE_BOOT, SAG_MODE_TEST, SAG_MODE_CONTACTLESS_FW: priv_level = SAG_LVL_SUPER;
			default: priv_level = SAG_LVL_USER;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Permission decision, fixed in logic apart from the two grant masks

	always_comb begin
		grant_bit = 1'b0;
		if (int'(unit_sel) < UNIT_N) begin
			if (priv_level == SAG_LVL_USER) begin
				grant_bit = user_grant_r[unit_sel];
			end else begin
				grant_bit = cfw_grant_r[unit_sel];
			end
		end
		allow = 1'b0;
		case (priv_level)
			SAG_LVL_USER: begin
				allow = is_core || (is_unit && grant_bit);
			end
			SAG_LVL_SYSTEM: begin
				allow = is_core || is_mmu || is_unit;
			end
			SAG_LVL_SUPER: begin
				// Boot and test reach all but the memory management window; contactless firmware needs a grant
				if (core_req.mode == SAG_MODE_CONTACTLESS_FW) begin
					allow = is_core || (is_unit && grant_bit);
				end else begin
					allow = 1'b1;
				end
			end
			default: allow = 1'b0;
		endcase
		// Pointer and grants stay system-only, boot and test included
		// Higher privilege must not bypass the descriptor list protection
		if (is_mmu && priv_level != SAG_LVL_SYSTEM) begin
			allow = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Forwarding to the bank; refused accesses never reach it

	assign bank_req.rd = core_req.rd & allow & ~is_mmu & clk_en;
	assign bank_req.wr = core_req.wr & allow & ~is_mmu & clk_en;
	assign bank_req.addr = core_req.addr;
	assign bank_req.wdata = core_req.wdata;
	assign core_denied = access & ~allow;

	// Status fields placed by the package's bit positions
	always_comb begin
		viol_stat = '0;
		viol_stat[SAG_VIOL_FLAG_BIT] = viol_r;
		viol_stat[SAG_VIOL_WRITE_BIT] = viol_wr_r;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			core_rdata <= '0;
		end else if (clk_en) begin
			if (!core_req.rd || !allow) begin
				core_rdata <= '0;
			end else if (is_mmu) begin
				case (core_req.addr)
					SAG_DESC_PTR_LO: core_rdata <= desc_ptr_r[7:0];
					SAG_DESC_PTR_HI: core_rdata <= desc_ptr_r[15:8];
					SAG_USER_GRANT: core_rdata <= 8'(user_grant_r);
					SAG_CFW_GRANT: core_rdata <= 8'(cfw_grant_r);
					SAG_VIOL_STAT: core_rdata <= viol_stat;
					default: core_rdata <= '0;
				endcase
			end else begin
				core_rdata <= bank_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Memory management configuration registers

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			desc_ptr_r <= SAG_DESC_PTR_RST;
		end else if (mmu_wr) begin
			if (core_req.addr == SAG_DESC_PTR_LO) begin
				desc_ptr_r[7:0] <= core_req.wdata;
			end
			if (core_req.addr == SAG_DESC_PTR_HI) begin
				desc_ptr_r[15:8] <= core_req.wdata;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			user_grant_r <= UNIT_N'(SAG_GRANT_RST);
			cfw_grant_r <= UNIT_N'(SAG_GRANT_RST);
		end else if (mmu_wr) begin
			if (core_req.addr == SAG_USER_GRANT) begin
				user_grant_r <= UNIT_N'(core_req.wdata);
			end
			if (core_req.addr == SAG_CFW_GRANT) begin
				cfw_grant_r <= UNIT_N'(core_req.wdata);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky violation flag; a new refusal wins over a clearing write

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			viol_r <= 1'b0;
			viol_wr_r <= 1'b0;
		end else if (clk_en) begin
			if (access && !allow) begin
				viol_r <= 1'b1;
				viol_wr_r <= core_req.wr;
			end else if (viol_clr) begin
				viol_r <= 1'b0;
				viol_wr_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-level stack limits; index 0 user, 1 system, 2 highest

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			for (int i = 0; i < 3; i++) begin
				stack_lim_r[i] <= SAG_STACK_LIM_RST;
			end
		end else if (clk_en && stack_lim_wr != 2'h3) begin
			stack_lim_r[stack_lim_wr] <= stack_lim_wdata;
		end
	end

	always_comb begin
		case (priv_level)
			SAG_LVL_USER: stack_limit = stack_lim_r[0];
			SAG_LVL_SYSTEM: stack_limit = stack_lim_r[1];
			SAG_LVL_SUPER: stack_limit = stack_lim_r[2];
			default: stack_limit = stack_lim_r[0];
		endcase
	end

	assign desc_list_ptr = desc_ptr_r;
	assign viol_flag = viol_r;

endmodule

// >>> include/sag_pkg.sv
// Package for the register access guard: modes, address map, field layout, reset values
package sag_pkg;

	// Processor execution modes, as presented by the core
	typedef enum logic [2:0] {
		SAG_MODE_USER = 3'h0,
		SAG_MODE_SYSTEM = 3'h1,
		SAG_MODE_BOOT = 3'h2,
		SAG_MODE_TEST = 3'h3,
		SAG_MODE_CONTACTLESS_FW = 3'h4
	} sag_mode_t;

	// Privilege levels
	typedef enum logic [2:0] {
		SAG_LVL_USER = 3'h1,
		SAG_LVL_SYSTEM = 3'h2,
		SAG_LVL_SUPER = 3'h4
	} sag_level_t;

	localparam int SAG_ADDR_W = 8;
	localparam int SAG_DATA_W = 8;
	localparam int SAG_UNIT_N = 8;

	// Address classes of the register space
	localparam logic [7:0] SAG_CORE_BASE = 8'h80;
	localparam logic [7:0] SAG_CORE_LAST = 8'h9f;
	localparam logic [7:0] SAG_MMU_BASE = 8'ha0;
	localparam logic [7:0] SAG_MMU_LAST = 8'hbf;
	localparam logic [7:0] SAG_UNIT_BASE = 8'hc0;
	localparam logic [7:0] SAG_UNIT_LAST = 8'hff;
	// Each hardware unit owns an 8-register slice; bits [5:3] pick the unit
	localparam int SAG_UNIT_SEL_LSB = 3;

	// Guard's own configuration registers inside the memory management window
	localparam logic [7:0] SAG_DESC_PTR_LO = 8'ha0;
	localparam logic [7:0] SAG_DESC_PTR_HI = 8'ha1;
	localparam logic [7:0] SAG_USER_GRANT = 8'ha2;
	localparam logic [7:0] SAG_CFW_GRANT = 8'ha3;
	localparam logic [7:0] SAG_VIOL_STAT = 8'ha4;

	// Restrictive reset values: null pointer, no grants, no violation
	localparam logic [15:0] SAG_DESC_PTR_RST = 16'h0000;
	localparam logic [7:0] SAG_GRANT_RST = 8'h00;

	// Violation status fields
	localparam int SAG_VIOL_FLAG_BIT = 0;
	localparam int SAG_VIOL_WRITE_BIT = 1;

	// Stack limit reset value per level
	localparam logic [7:0] SAG_STACK_LIM_RST = 8'hff;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [SAG_ADDR_W-1:0] addr;
		logic [SAG_DATA_W-1:0] wdata;
		sag_mode_t mode;
	} sag_req_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [SAG_ADDR_W-1:0] addr;
		logic [SAG_DATA_W-1:0] wdata;
	} sag_bank_req_t;

endpackage

// >>> tb/sag_monitor.sv
// Checker for the register access guard
`timescale 1ns/100ps
module sag_monitor
	import sag_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	input wire sag_req_t core_req,
	input wire logic [7:0] core_rdata,
	input wire logic core_denied,
	input wire sag_bank_req_t bank_req,
	input wire logic [7:0] bank_rdata,
	input wire sag_level_t priv_level,
	input wire logic [15:0] desc_list_ptr,
	input wire logic viol_flag
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	wire logic en = clk_en && (core_req.rd || core_req.wr);
	wire logic usr = core_req.mode == SAG_MODE_USER;
	wire logic sys = core_req.mode == SAG_MODE_SYSTEM;
	wire logic mmu = core_req.addr[7:5] == 3'h5;
	////////////////////////////////////////////////////////////////
	chk_user_core_ok: assert property (en && usr && core_req.addr[7:5] == 3'h4 |-> !core_denied)
		else $error("user core access refused");
	chk_user_mmu_deny: assert property (en && usr && mmu |-> core_denied && !bank_req.rd && !bank_req.wr)
		else $error("user reached mmu window");
	chk_sys_unit_ok: assert property (en && sys && core_req.addr[7:6] == 2'h3 |-> !core_denied && bank_req.rd == core_req.rd)
		else $error("system unit access blocked");
	chk_deny_effect: assert property (en && core_denied |=> viol_flag && core_rdata == 8'h00)
		else $error("refusal without flag or zero");
	chk_viol_sticky: assert property (viol_flag && !(core_req.wr && core_req.addr == SAG_VIOL_STAT) |=> viol_flag)
		else $error("violation flag dropped");
	chk_ptr_write: assert property (en && sys && core_req.wr && core_req.addr == SAG_DESC_PTR_LO |=> desc_list_ptr[7:0] == $past(core_req.wdata))
		else $error("pointer write lost");
	chk_ptr_guard: assert property (!sys |=> $stable(desc_list_ptr))
		else $error("pointer changed outside system");
	chk_level_map: assert property (priv_level == (usr ? SAG_LVL_USER : sys ? SAG_LVL_SYSTEM : SAG_LVL_SUPER))
		else $error("wrong privilege level");
	chk_rdata_pass: assert property (en && bank_req.rd |=> core_rdata == $past(bank_rdata))
		else $error("read data not passed");
	cover property (en && usr && bank_req.rd && core_req.addr[7:6] == 2'h3);
	cover property (en && core_denied);
	cover property (desc_list_ptr != 16'h0000);
endmodule
bind sag_guard sag_monitor chk_i (.*);

// >>> tb/sag_bank_model.sv
// Behavioural register bank behind the guard
`timescale 1ns/100ps
module sag_bank_model
	import sag_pkg::*;
(
	input wire logic clk_sys,
	input wire sag_bank_req_t bank_req,
	output logic [7:0] bank_rdata
);
	logic [7:0] mem [256];
	logic [7:0] last_r = 8'h00;
	initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
	// Idle bus shows inverted last value so stale data never matches
	always_comb bank_rdata = bank_req.rd ? mem[bank_req.addr] : ~last_r;
	always @(posedge clk_sys) begin
		if (bank_req.wr) mem[bank_req.addr] <= bank_req.wdata;
		if (bank_req.rd) last_r <= mem[bank_req.addr];
	end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the register access guard
`timescale 1ns/100ps
module testbench
	import sag_pkg::*;
;
	localparam sag_mode_t U = SAG_MODE_USER, S = SAG_MODE_SYSTEM, C = SAG_MODE_CONTACTLESS_FW;
	logic clk_sys, reset, clk_en, viol_flag, core_denied;
	sag_req_t core_req;
	sag_bank_req_t bank_req;
	logic [7:0] core_rdata, bank_rdata, stack_lim_wdata, stack_limit;
	logic [1:0] stack_lim_wr;
	sag_level_t priv_level;
	logic [15:0] desc_list_ptr;
	int error_cnt = 0;
	int tests_run = 0;
	sag_guard uut (.*);
	sag_bank_model bank (.*);
	always #2 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Access held one cycle; caller follows with another access or idle
	task automatic acc(input sag_mode_t m, input logic w, input logic [7:0] a, d, input logic dn,
		input logic [7:0] exp);
		core_req = '{rd: !w, wr: w, addr: a, wdata: d, mode: m};
		#2 chk(16'(core_denied), 16'(dn));
		@(posedge clk_sys);
		#1 if (!w) chk(16'(core_rdata), 16'(exp));
	endtask
	////////////////////////////////////////////////////////////////
	task automatic s_ptr;
		acc(S, 1, 8'ha0, 8'h12, 0, 0);
		acc(S, 1, 8'ha1, 8'h34, 0, 0);
		acc(U, 1, 8'ha0, 8'hff, 1, 0);
		acc(SAG_MODE_TEST, 1, 8'ha1, 8'hff, 1, 0);
		acc(SAG_MODE_BOOT, 1, 8'ha0, 8'hff, 1, 0);
		acc(S, 0, 8'ha1, 8'h00, 0, 8'h34);
		acc(S, 0, 8'ha4, 8'h00, 0, 8'h03);
		acc(S, 1, 8'ha4, 8'h01, 0, 0);
		core_req = '0;
		chk(desc_list_ptr, 16'h3412);
		chk(16'(viol_flag), 16'h0000);
	endtask
	task automatic s_grant;
		acc(U, 0, 8'hc8, 8'h00, 1, 8'h00);
		acc(S, 1, 8'ha2, 8'h02, 0, 0);
		acc(U, 0, 8'h85, 8'h00, 0, 8'h85 ^ 8'h5a);
		acc(U, 0, 8'hc8, 8'h00, 0, 8'hc8 ^ 8'h5a);
		acc(U, 0, 8'hc0, 8'h00, 1, 8'h00);
		acc(U, 1, 8'hc9, 8'h77, 0, 0);
		acc(C, 0, 8'hc8, 8'h00, 1, 8'h00);
		acc(S, 1, 8'ha3, 8'h01, 0, 0);
		acc(C, 0, 8'hc3, 8'h00, 0, 8'hc3 ^ 8'h5a);
		acc(S, 0, 8'hc9, 8'h00, 0, 8'h77);
		acc(S, 0, 8'hf8, 8'h00, 0, 8'hf8 ^ 8'h5a);
		core_req = '0;
		chk(16'(viol_flag), 16'h0001);
	endtask
	task automatic s_stack;
		stack_lim_wr = 2'h1;
		stack_lim_wdata = 8'h5a;
		core_req.mode = S;
		@(posedge clk_sys);
		#1 stack_lim_wr = 2'h3;
		chk(16'(stack_limit), 16'h005a);
		chk(16'(priv_level), 16'(SAG_LVL_SYSTEM));
		core_req.mode = C;
		@(posedge clk_sys);
		#1 chk(16'(stack_limit), 16'h00ff);
		chk(16'(priv_level), 16'(SAG_LVL_SUPER));
	endtask
	// Mid-run reset must bring back the restrictive defaults
	task automatic s_reset;
		acc(S, 1, 8'ha0, 8'h55, 0, 0);
		core_req.wr = 1'b0;
		reset = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 reset = 1'b0;
		chk(desc_list_ptr, 16'h0000);
		chk(16'(viol_flag), 16'h0000);
		chk(16'(stack_limit), 16'h00ff);
		acc(U, 0, 8'hc8, 8'h00, 1, 8'h00);
		acc(S, 0, 8'ha2, 8'h00, 0, 8'h00);
	endtask
	// Low clock enable freezes the pointer and blocks bank strobes
	task automatic s_freeze;
		clk_en = 1'b0;
		acc(S, 1, 8'ha0, 8'h66, 0, 0);
		acc(S, 1, 8'hc2, 8'hee, 0, 0);
		clk_en = 1'b1;
		acc(S, 0, 8'hc2, 8'h00, 0, 8'hc2 ^ 8'h5a);
		chk(desc_list_ptr, 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#20000 error_cnt++;
		end_sim();
	end
	initial begin
		clk_sys = 1'b0;
		reset = 1'b1;
		clk_en = 1'b1;
		core_req = '0;
		stack_lim_wr = 2'h3;
		stack_lim_wdata = 8'h00;
		repeat (10) @(posedge clk_sys);
		#1 reset = 1'b0;
		chk(desc_list_ptr, 16'h0000);
		chk(16'(viol_flag), 16'h0000);
		chk(16'(stack_limit), 16'h00ff);
		s_ptr();
		s_grant();
		s_stack();
		s_reset();
		s_freeze();
		end_sim();
	end
endmodule
